//--- rtl/i2cst_gen_if.sv
`timescale 1ns/1ps
interface i2cst_gen_if;
	logic launch;
	logic abort;
	logic handoff;
	logic scl_hi;
	logic sda_hi;
	logic other_start;
	logic busy;
	logic done;
	logic lost;
	logic sda_low;
	logic scl_low;
	modport ctrl(output launch, abort, handoff, scl_hi, sda_hi, other_start,
		input busy, done, lost, sda_low, scl_low);
	modport gen(input launch, abort, handoff, scl_hi, sda_hi, other_start,
		output busy, done, lost, sda_low, scl_low);
endinterface : i2cst_gen_if

//--- rtl/i2cst_pkg.sv
package i2cst_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int HCLK_PERIOD_NS = 20;
	localparam int T_SU_STA_NS = 4700;
	localparam int T_HD_STA_NS = 4000;
	localparam int SU_CYCLES = (T_SU_STA_NS + HCLK_PERIOD_NS - 1) / HCLK_PERIOD_NS;
	localparam int HD_CYCLES = (T_HD_STA_NS + HCLK_PERIOD_NS - 1) / HCLK_PERIOD_NS;
	localparam int CNT_W = 16;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FLAG = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0c;
	localparam logic [7:0] OFS_BUS = 8'h10;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_START_BIT = 1;
	localparam int CTRL_RELEASE_BIT = 2;
	localparam int FLAG_RSV_DIS_BIT = 0;
	localparam int FLAG_START_FAIL_BIT = 7;
	localparam int EV_START_DONE = 0;
	localparam int EV_START_FAIL = 1;
	localparam int EV_ARB_LOST = 2;
	localparam int EV_STOP = 3;
	localparam int EV_START_SEEN = 4;
	localparam int NUM_EV = 5;
	localparam int BUS_BUSY_BIT = 0;
	localparam int BUS_MASTER_BIT = 1;
	localparam int BUS_PEND_BIT = 2;
	localparam int BUS_WAIT_BIT = 3;
	localparam logic [NUM_EV-1:0] EV_RST = 5'h00;
	localparam logic [NUM_EV-1:0] MASK_RST = 5'h00;
	// ----------------------------------------------------------------
	// Start sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		GEN_IDLE = 3'b000,
		GEN_RELEASE = 3'b001,
		GEN_SETUP = 3'b011,
		GEN_HOLD = 3'b010,
		GEN_OWN = 3'b110
	} i2cst_gen_state_t;
endpackage : i2cst_pkg

//--- rtl/i2cst_start_ctrl.sv
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module i2cst_start_ctrl
	import i2cst_pkg::*;
#(
	parameter int SU_CNT = SU_CYCLES,
	parameter int HD_CNT = HD_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic serial_clock_line_in,
	output logic serial_clock_line_out,
	output logic serial_clock_line_oe,
	input wire logic serial_data_line_in,
	output logic serial_data_line_out,
	output logic serial_data_line_oe,
	input wire logic master_wait,
	input wire logic arb_lost_in,
	input wire logic ctrl_takeover,
	output logic wait_release,
	output logic irq
);
	// Counts below one or beyond the counter width would wrap the sequencer
	if (SU_CNT < 1 || HD_CNT < 1 || SU_CNT >= 2**CNT_W || HD_CNT >= 2**CNT_W) begin : g_bad_cnt
		$error("i2cst_start_ctrl: setup and hold counts must fit the counter");
	end
	// ----------------------------------------------------------------
	// Line sampling and bus monitor
	// ----------------------------------------------------------------
	logic [1:0] line_level;
	logic [1:0] line_rise;
	logic [1:0] line_fall;
	logic scl_hi;
	logic sda_hi;
	logic start_seen;
	logic stop_seen;
	logic bus_busy_reg;

	i2cst_sync #(
		.WIDTH(2)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.async_in({serial_clock_line_in, serial_data_line_in}),
		.level(line_level),
		.rise(line_rise),
		.fall(line_fall)
	);

	assign scl_hi = line_level[1];
	assign sda_hi = line_level[0];
	assign start_seen = line_fall[0] & scl_hi;
	assign stop_seen = line_rise[0] & scl_hi;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_busy_reg <= 1'b0;
		end else if (ce) begin
			if (start_seen) bus_busy_reg <= 1'b1;
			else if (stop_seen) bus_busy_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	logic addr_take;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] rd_word;
	logic wr_ctrl;
	logic wr_flag;
	logic wr_mask;
	logic rd_stat;

	logic enable_reg;
	logic trigger_reg;
	logic restart_reg;
	logic release_reg;
	logic resv_dis_reg;
	logic start_fail_reg;
	logic master_reg;
	logic wait_rel_reg;
	logic [NUM_EV-1:0] status_reg;
	logic [NUM_EV-1:0] mask_reg;
	logic [NUM_EV-1:0] events;
	logic sda_oe_reg;
	logic scl_oe_reg;

	// Stall while frozen so no transfer completes against halted registers
	assign hreadyout = ce;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign addr_take = hsel & htrans[1] & hready & ce;
	assign wr_ctrl = wr_pend_reg && wr_addr_reg == OFS_CTRL && ce;
	assign wr_flag = wr_pend_reg && wr_addr_reg == OFS_FLAG && ce;
	assign wr_mask = wr_pend_reg && wr_addr_reg == OFS_MASK && ce;
	assign rd_stat = addr_take && !hwrite && haddr[7:0] == OFS_STAT && haddr[31:8] == 24'h000000;

	always_comb begin
		rd_word = 32'h00000000;
		if (haddr[31:8] == 24'h000000) begin
			case (haddr[7:0])
				OFS_CTRL: begin
					rd_word[CTRL_ENABLE_BIT] = enable_reg;
					// Trigger and release read back as zero
					rd_word[CTRL_START_BIT] = 1'b0;
				end
				OFS_FLAG: begin
					rd_word[FLAG_RSV_DIS_BIT] = resv_dis_reg;
					rd_word[FLAG_START_FAIL_BIT] = start_fail_reg;
				end
				OFS_STAT: rd_word[NUM_EV-1:0] = status_reg;
				OFS_MASK: rd_word[NUM_EV-1:0] = mask_reg;
				OFS_BUS: begin
					rd_word[BUS_BUSY_BIT] = bus_busy_reg;
					rd_word[BUS_MASTER_BIT] = master_reg;
					rd_word[BUS_PEND_BIT] = trigger_reg;
					rd_word[BUS_WAIT_BIT] = master_wait;
				end
				default: rd_word = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_reg <= 32'h00000000;
		end else if (ce) begin
			if (hready) begin
				wr_pend_reg <= addr_take & hwrite & (haddr[31:8] == 24'h000000);
				wr_addr_reg <= haddr[7:0];
			end
			if (addr_take && !hwrite) hrdata_reg <= rd_word;
		end
	end

	// ----------------------------------------------------------------
	// Control and flag registers
	// ----------------------------------------------------------------
	logic en_eff;
	logic sw_start;
	logic sw_clear;
	logic rel_req;
	logic kill;
	logic accept_wait;
	logic accept_free;
	logic accept_resv;
	logic refuse;
	logic arb_lost;

	i2cst_gen_if gi ();

	assign en_eff = wr_ctrl ? hwdata[CTRL_ENABLE_BIT] : enable_reg;
	assign rel_req = wr_ctrl & hwdata[CTRL_RELEASE_BIT];
	assign sw_start = wr_ctrl & hwdata[CTRL_START_BIT] & en_eff & ~rel_req;
	assign sw_clear = wr_ctrl & ~hwdata[CTRL_START_BIT];
	assign arb_lost = gi.lost | (arb_lost_in & (trigger_reg | master_reg));
	assign kill = ~en_eff | release_reg | rel_req;
	assign accept_wait = sw_start & master_reg & master_wait;
	assign accept_free = sw_start & ~accept_wait & ~bus_busy_reg;
	assign accept_resv = sw_start & ~accept_wait & bus_busy_reg & ~resv_dis_reg;
	assign refuse = sw_start & ~accept_wait & bus_busy_reg & resv_dis_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable_reg <= 1'b0;
		end else if (ce) begin
			if (wr_ctrl) enable_reg <= hwdata[CTRL_ENABLE_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			release_reg <= 1'b0;
		end else if (ce) begin
			// Release is a self-clearing one-cycle command
			release_reg <= rel_req & en_eff;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trigger_reg <= 1'b0;
		end else if (ce) begin
			if (kill || arb_lost || gi.done) begin
				trigger_reg <= 1'b0;
			end else if (accept_wait || accept_free || accept_resv) begin
				trigger_reg <= 1'b1;
			end else if (sw_clear) begin
				trigger_reg <= 1'b0;
			end
		end
	end

	// Remembers that the pending trigger came from the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			restart_reg <= 1'b0;
		end else if (ce) begin
			if (kill || arb_lost || gi.done || sw_clear) restart_reg <= 1'b0;
			else if (accept_wait || accept_free || accept_resv) restart_reg <= accept_wait;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			resv_dis_reg <= 1'b0;
		end else if (ce) begin
			if (wr_flag) resv_dis_reg <= hwdata[FLAG_RSV_DIS_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			start_fail_reg <= 1'b0;
		end else if (ce) begin
			// A refused start wins over any clear in the same cycle
			if (refuse) start_fail_reg <= 1'b1;
			else if (kill || accept_free || accept_resv || accept_wait) start_fail_reg <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			master_reg <= 1'b0;
		end else if (ce) begin
			if (gi.done) master_reg <= 1'b1;
			else if (kill || stop_seen || arb_lost) master_reg <= 1'b0;
		end
	end

	// One-cycle pulse asks the rest of the controller to let the wait go
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_rel_reg <= 1'b0;
		end else if (ce) begin
			wait_rel_reg <= accept_wait & ~kill;
		end
	end

	assign wait_release = wait_rel_reg;

	// ----------------------------------------------------------------
	// Start sequencer
	// ----------------------------------------------------------------
	// Restart proceeds on a busy bus; a fresh start waits for bus free
	assign gi.launch = trigger_reg & ~gi.busy & enable_reg
		& (restart_reg | ~bus_busy_reg);
	assign gi.abort = kill | arb_lost_in;
	assign gi.handoff = ctrl_takeover | stop_seen;
	assign gi.scl_hi = scl_hi;
	assign gi.sda_hi = sda_hi;
	assign gi.other_start = start_seen;

	i2cst_start_gen #(
		.SU_CNT(SU_CNT),
		.HD_CNT(HD_CNT)
	) u_gen (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.g(gi)
	);

	// ----------------------------------------------------------------
	// Open-drain pins
	// ----------------------------------------------------------------
	// Drive only pulls low; a disabled controller leaves both lines floating
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sda_oe_reg <= 1'b0;
		end else if (ce) begin
			sda_oe_reg <= gi.sda_low & ~kill;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scl_oe_reg <= 1'b0;
		end else if (ce) begin
			scl_oe_reg <= gi.scl_low & ~kill;
		end
	end

	assign serial_data_line_out = 1'b0;
	assign serial_clock_line_out = 1'b0;
	assign serial_data_line_oe = sda_oe_reg;
	assign serial_clock_line_oe = scl_oe_reg;

	// ----------------------------------------------------------------
	// Interrupt status
	// ----------------------------------------------------------------
	always_comb begin
		events = EV_RST;
		events[EV_START_DONE] = gi.done;
		events[EV_START_FAIL] = refuse;
		events[EV_ARB_LOST] = arb_lost;
		events[EV_STOP] = stop_seen;
		events[EV_START_SEEN] = start_seen;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_reg <= EV_RST;
		end else if (ce) begin
			// New events win over the clear-on-read
			status_reg <= (rd_stat ? EV_RST : status_reg) | events;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_reg <= MASK_RST;
		end else if (ce) begin
			if (wr_mask) mask_reg <= hwdata[NUM_EV-1:0];
		end
	end

	assign irq = |(status_reg & mask_reg);
endmodule : i2cst_start_ctrl

//--- rtl/i2cst_start_gen.sv
`timescale 1ns/1ps
module i2cst_start_gen
	import i2cst_pkg::*;
#(
	parameter int SU_CNT = SU_CYCLES,
	parameter int HD_CNT = HD_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	i2cst_gen_if.gen g
);
	if (SU_CNT < 1 || HD_CNT < 1 || SU_CNT >= 2**CNT_W || HD_CNT >= 2**CNT_W) begin : g_bad
		$error("i2cst_start_gen: setup and hold counts must fit the counter");
	end
	localparam logic [CNT_W-1:0] SU_LAST = CNT_W'(SU_CNT - 1);
	localparam logic [CNT_W-1:0] HD_LAST = CNT_W'(HD_CNT - 1);

	i2cst_gen_state_t state_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic done_reg;
	logic lost_reg;
	logic lines_hi;

	assign lines_hi = g.scl_hi & g.sda_hi;

	// ----------------------------------------------------------------
	// Sequencer: release, bus-free setup, data low, hold, clock low
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= GEN_IDLE;
		end else if (ce) begin
			case (state_reg)
				GEN_IDLE: begin
					if (g.launch && !g.abort) state_reg <= GEN_RELEASE;
				end
				GEN_RELEASE: begin
					if (g.abort) state_reg <= GEN_IDLE;
					else if (lines_hi) state_reg <= GEN_SETUP;
				end
				GEN_SETUP: begin
					if (g.abort || g.other_start) state_reg <= GEN_IDLE;
					else if (!lines_hi) state_reg <= GEN_RELEASE;
					else if (cnt_reg == SU_LAST) state_reg <= GEN_HOLD;
				end
				GEN_HOLD: begin
					if (g.abort) state_reg <= GEN_IDLE;
					else if (cnt_reg == HD_LAST) state_reg <= GEN_OWN;
				end
				GEN_OWN: begin
					if (g.abort || g.handoff) state_reg <= GEN_IDLE;
				end
				default: state_reg <= GEN_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= '0;
		end else if (ce) begin
			if (state_reg == GEN_SETUP && cnt_reg != SU_LAST && lines_hi) cnt_reg <= cnt_reg + 1'b1;
			else if (state_reg == GEN_HOLD && cnt_reg != HD_LAST) cnt_reg <= cnt_reg + 1'b1;
			else cnt_reg <= '0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_reg <= 1'b0;
			lost_reg <= 1'b0;
		end else if (ce) begin
			done_reg <= state_reg == GEN_HOLD && cnt_reg == HD_LAST && !g.abort;
			// Another master started while we waited for bus-free time
			lost_reg <= state_reg == GEN_SETUP && g.other_start && !g.abort;
		end
	end

	assign g.busy = state_reg != GEN_IDLE;
	assign g.done = done_reg;
	assign g.lost = lost_reg;
	assign g.sda_low = state_reg == GEN_HOLD || state_reg == GEN_OWN;
	assign g.scl_low = state_reg == GEN_OWN;
endmodule : i2cst_start_gen

//--- rtl/i2cst_sync.sv
`timescale 1ns/1ps
module i2cst_sync #(
	parameter int WIDTH = 2
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);
	if (WIDTH < 1) begin : g_bad_width
		$error("i2cst_sync: WIDTH must be at least 1");
	end
	// ----------------------------------------------------------------
	// Two-stage synchroniser with edge detect behind the second stage
	// ----------------------------------------------------------------
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic meta_reg;
		logic stab_reg;
		logic prev_reg;
		// Idle bus lines are pulled high, so reset to high avoids a false edge
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				meta_reg <= 1'b1;
				stab_reg <= 1'b1;
				prev_reg <= 1'b1;
			end else if (ce) begin
				meta_reg <= async_in[i];
				stab_reg <= meta_reg;
				prev_reg <= stab_reg;
			end
		end
		assign level[i] = stab_reg;
		assign rise[i] = stab_reg & ~prev_reg;
		assign fall[i] = ~stab_reg & prev_reg;
	end
endmodule : i2cst_sync

//--- tb/i2cst_asserts.sv
`timescale 1ns/1ps
module i2cst_asserts
	import i2cst_pkg::*;
#(
	parameter int HD_CNT = HD_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic serial_clock_line_out,
	input wire logic serial_clock_line_oe,
	input wire logic serial_data_line_out,
	input wire logic serial_data_line_oe,
	input wire logic master_wait,
	input wire logic arb_lost_in,
	input wire logic wait_release
);
	logic wr_ctrl_reg;
	logic rd_ctrl_reg;
	logic [15:0] hold_reg;
	logic take;
	assign take = hsel && htrans[1] && hready && ce && (haddr == 32'(OFS_CTRL));
	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ctrl_reg <= 1'b0;
			rd_ctrl_reg <= 1'b0;
		end else begin
			wr_ctrl_reg <= take && hwrite;
			rd_ctrl_reg <= take && !hwrite;
		end
	end
	// Cycles with data pulled low and clock still free
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_reg <= 16'h0000;
		end else if (!serial_data_line_oe) begin
			hold_reg <= 16'h0000;
		end else if (!serial_clock_line_oe) begin
			hold_reg <= hold_reg + 16'h0001;
		end
	end
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_data_before_clock: assert property ($rose(serial_data_line_oe) |-> !serial_clock_line_oe)
		else $error("data line pulled low after the clock line");
	a_clock_after_data: assert property ($rose(serial_clock_line_oe) |-> serial_data_line_oe)
		else $error("clock line pulled low without data line low");
	a_hold_time_count: assert property ($rose(serial_clock_line_oe) |-> hold_reg == 16'(HD_CNT))
		else $error("start hold time differs from the set count");
	a_open_drain_low: assert property (!serial_clock_line_out && !serial_data_line_out)
		else $error("line output driven high");
	a_wait_release_pulse: assert property (wait_release |=> !wait_release)
		else $error("wait release longer than one cycle");
	a_wait_release_cause: assert property (wait_release |-> $past(master_wait))
		else $error("wait release without master wait");
	a_release_floats_lines: assert property (wr_ctrl_reg && (hwdata[CTRL_RELEASE_BIT]
		|| !hwdata[CTRL_ENABLE_BIT]) |=> ##1 !serial_data_line_oe && !serial_clock_line_oe)
		else $error("lines still driven after release or disable");
	a_trigger_reads_zero: assert property (rd_ctrl_reg |-> !hrdata[CTRL_START_BIT]
		&& !hrdata[CTRL_RELEASE_BIT])
		else $error("command bits read back as one");
	a_arb_loss_cancels: assert property (arb_lost_in && !serial_data_line_oe
		|=> !serial_data_line_oe [*8])
		else $error("start made after arbitration loss");
	a_ready_okay: assert property (hreadyout == ce && !hresp)
		else $error("bus answer not ready and okay");
	c_start_made: cover property ($rose(serial_clock_line_oe));
	c_restart: cover property (wait_release);
	c_arb_cancel: cover property (arb_lost_in && !serial_data_line_oe);
endmodule : i2cst_asserts

bind i2cst_start_ctrl i2cst_asserts #(.HD_CNT(HD_CNT)) i2cst_asserts_inst (.hclk, .hresetn, .ce,
	.hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
	.serial_clock_line_out, .serial_clock_line_oe, .serial_data_line_out, .serial_data_line_oe,
	.master_wait, .arb_lost_in, .wait_release);

//--- tb/i2cst_bus_model.sv
`timescale 1ns/1ps
module i2cst_bus_model (
	input wire logic scl_oe,
	input wire logic scl_out,
	input wire logic sda_oe,
	input wire logic sda_out,
	output logic scl,
	output logic sda
);
	logic scl_low = 1'b0;
	logic sda_low = 1'b0;
	// Pull-ups: a released line reads high, so no stale level survives
	assign scl = !((scl_oe && !scl_out) || scl_low);
	assign sda = !((sda_oe && !sda_out) || sda_low);
	// Foreign start, then two bit clocks at 160 ns; clock stands high after
	task start_frame;
		sda_low = 1'b1;
		#80 scl_low = 1'b1;
		#80 sda_low = 1'b0;
		repeat (2) begin
			#80 scl_low = 1'b0;
			#80 scl_low = 1'b1;
		end
		#80 scl_low = 1'b0;
		#80;
	endtask : start_frame
	task stop_frame;
		scl_low = 1'b1;
		#80 sda_low = 1'b1;
		#80 scl_low = 1'b0;
		#80 sda_low = 1'b0;
		#80;
	endtask : stop_frame
endmodule : i2cst_bus_model

//--- tb/tb_i2c_start_trigger_control.sv
`timescale 1ns/1ps
module tb_i2c_start_trigger_control;
	import i2cst_pkg::*;
	localparam int SU = 4;
	localparam int HD = 4;
	logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic master_wait = 1'b0, arb_lost_in = 1'b0, ctrl_takeover = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hready, hreadyout, hresp, wait_release, irq, hit;
	logic serial_clock_line_in, serial_clock_line_out, serial_clock_line_oe;
	logic serial_data_line_in, serial_data_line_out, serial_data_line_oe;
	int errors = 0, check_count = 0;
	always #10 hclk = ~hclk;
	assign hready = hreadyout;
	i2cst_start_ctrl #(.SU_CNT(SU), .HD_CNT(HD)) i2cst_start_ctrl_inst (.hclk, .hresetn, .ce,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
		.serial_clock_line_in, .serial_clock_line_out, .serial_clock_line_oe,
		.serial_data_line_in, .serial_data_line_out, .serial_data_line_oe,
		.master_wait, .arb_lost_in, .ctrl_takeover, .wait_release, .irq);
	i2cst_bus_model i2cst_bus_model_inst (.scl_oe(serial_clock_line_oe),
		.scl_out(serial_clock_line_out), .sda_oe(serial_data_line_oe),
		.sda_out(serial_data_line_out), .scl(serial_clock_line_in), .sda(serial_data_line_in));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
			errors++;
		end
	endtask : check
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : ahb
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask : wr
	task rdchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		check(n, r & m, e);
	endtask : rdchk
	// Bounded wait for the data line to be pulled low
	task sda_wait(input int n);
		for (int i = 0; i < n && serial_data_line_oe !== 1'b1; i++) @(posedge hclk);
		hit = serial_data_line_oe;
	endtask : sda_wait
	// The rest of the controller keeps the clock low once it owns the lines,
	// so releasing our pulls must not look like a stop on the bus
	task takeover;
		i2cst_bus_model_inst.scl_low = 1'b1;
		ctrl_takeover <= 1'b1;
		@(posedge hclk);
		ctrl_takeover <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask : takeover
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_regs;
		rdchk("ctrl_rst", OFS_CTRL, 32'hffffffff, 32'h0);
		rdchk("bus_rst", OFS_BUS, 32'hffffffff, 32'h0);
		wr(OFS_FLAG, 32'h81);
		rdchk("flag_rw", OFS_FLAG, 32'hffffffff, 32'h1);
		wr(8'h14, 32'hff);
		rdchk("unmapped", 8'h14, 32'hffffffff, 32'h0);
		wr(OFS_FLAG, 32'h0);
		wr(OFS_MASK, 32'h1f);
		rdchk("mask", OFS_MASK, 32'hffffffff, 32'h1f);
		wr(OFS_CTRL, 32'h2);
		sda_wait(40);
		check("start_while_off", 32'(hit), 32'h0);
		ce <= 1'b0;
		repeat (2) @(posedge hclk);
		check("frozen_ready", 32'(hreadyout), 32'h0);
		ce <= 1'b1;
		$display("test regs done");
	endtask : t_regs
	task t_start;
		wr(OFS_CTRL, 32'h1);
		wr(OFS_CTRL, 32'h3);
		rdchk("trig_reads0", OFS_CTRL, 32'hffffffff, 32'h1);
		sda_wait(100);
		check("start_data", 32'(hit), 32'h1);
		check("start_clock", 32'(serial_clock_line_oe), 32'h0);
		repeat (HD + 3) @(posedge hclk);
		check("start_clock_low", 32'(serial_clock_line_oe), 32'h1);
		check("irq_set", 32'(irq), 32'h1);
		rdchk("stat_done", OFS_STAT, 32'h1, 32'h1);
		check("irq_clear", 32'(irq), 32'h0);
		rdchk("bus_master", OFS_BUS, 32'h7, 32'h3);
		takeover();
		master_wait <= 1'b1;
		wr(OFS_CTRL, 32'h3);
		hit = 1'b0;
		repeat (4) begin
			@(posedge hclk);
			hit = hit | wait_release;
		end
		check("wait_release", 32'(hit), 32'h1);
		master_wait <= 1'b0;
		// Wait let go: the clock is free again for the repeated start
		i2cst_bus_model_inst.scl_low = 1'b0;
		sda_wait(100);
		check("restart", 32'(hit), 32'h1);
		repeat (HD + 3) @(posedge hclk);
		takeover();
		i2cst_bus_model_inst.stop_frame();
		rdchk("bus_free", OFS_BUS, 32'h1, 32'h0);
		$display("test start done");
	endtask : t_start
	task t_refused;
		wr(OFS_FLAG, 32'h1);
		i2cst_bus_model_inst.start_frame();
		wr(OFS_CTRL, 32'h3);
		rdchk("fail_flag", OFS_FLAG, 32'h81, 32'h81);
		rdchk("no_pend", OFS_BUS, 32'h5, 32'h1);
		i2cst_bus_model_inst.stop_frame();
		sda_wait(60);
		check("no_start", 32'(hit), 32'h0);
		rdchk("stat_fail", OFS_STAT, 32'h2, 32'h2);
		wr(OFS_FLAG, 32'h0);
		$display("test refused done");
	endtask : t_refused
	// Reserved trigger on a busy bus, then cancelled in each way or let run
	task t_reserve;
		for (int k = 0; k < 5; k++) begin
			wr(OFS_CTRL, 32'h1);
			i2cst_bus_model_inst.start_frame();
			wr(OFS_CTRL, 32'h3);
			rdchk("pend", OFS_BUS, 32'h5, 32'h5);
			if (k == 0) begin
				arb_lost_in <= 1'b1;
				@(posedge hclk);
				arb_lost_in <= 1'b0;
			end
			if (k > 0 && k < 4) wr(OFS_CTRL, (k == 1) ? 32'h5 : (k == 2) ? 32'h0 : 32'h1);
			rdchk("pend_after", OFS_BUS, 32'h4, (k == 4) ? 32'h4 : 32'h0);
			i2cst_bus_model_inst.stop_frame();
			sda_wait(100);
			check("reserved_start", 32'(hit), 32'(k == 4));
			if (k == 4) begin
				repeat (HD + 3) @(posedge hclk);
				takeover();
				i2cst_bus_model_inst.stop_frame();
			end
		end
		$display("test reserve done");
	endtask : t_reserve
	task summarize;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_start();
		t_refused();
		t_reserve();
		summarize();
	end
	// Whole run takes well under 100 us
	initial begin
		#400us;
		errors++;
		summarize();
	end
endmodule : tb_i2c_start_trigger_control
